// >>> rtl/twu_defs.svh
// Functional notes
// - four 32-bit timers; time stamp advances each timer clock, the others only while enabled
// - reserved bits ignored, read as zero
// - watchdog registers reached only over bus
// - watchdog writes need key 0x482e present
// - watchdog decrements while count enable set
// - watchdog zero raises interrupt if enabled
// - write one clears watchdog interrupt status
// - watchdog zero with reset enable resets chip
// - warm reset flag cleared by write one
// - reset clears watchdog enables, counter all ones
// - time stamp counts up from zero, wraps
// - time stamp wrap interrupt, write one clears
// - reload fills bits 31:2, low bits zero
// - writing reload loads counter immediately
// - timer counts only while enable bit set
// - periodic expiry reloads, interrupts, keeps counting
// - single run expiry reloads, interrupts, stops
// - each timer own interrupt and status bit
// - reset clears reload, counter, disables timer
// - reload bits: value, single run, enable
// - period is four times reload plus one
`ifndef TWU_DEFS_SVH
`define TWU_DEFS_SVH
`define TWU_OFS_TS 8'h00
`define TWU_OFS_GP0 8'h04
`define TWU_OFS_GP0_RL 8'h08
`define TWU_OFS_GP1 8'h0c
`define TWU_OFS_GP1_RL 8'h10
`define TWU_OFS_WD 8'h14
`define TWU_OFS_WD_CTL 8'h18
`define TWU_OFS_WD_KEY 8'h1c
`define TWU_OFS_STS 8'h20
`define TWU_KEY_VALUE 16'h482e
`define TWU_WD_RST 32'hffffffff
`define TWU_RL_EN_BIT 0
`define TWU_RL_SR_BIT 1
`define TWU_WCTL_RST_BIT 0
`define TWU_WCTL_INT_BIT 1
`define TWU_WCTL_CNT_BIT 2
`define TWU_ST_TS_BIT 0
`define TWU_ST_GP0_BIT 1
`define TWU_ST_GP1_BIT 2
`define TWU_ST_WD_BIT 3
`define TWU_ST_WARM_BIT 4
`endif

// >>> rtl/twu_pkg.sv
`default_nettype none
package twu_pkg;
  typedef logic [31:0] twu_word_t;
  typedef logic [29:0] twu_reload_t;
endpackage : twu_pkg
`default_nettype wire

// >>> rtl/twu_timer_unit.sv
`include "twu_defs.svh"
`default_nettype none
module twu_timer_unit (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic sys_rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic ts_irq_o,
  output logic gp0_irq_o,
  output logic gp1_irq_o,
  output logic wd_irq_o,
  output logic chip_rst_o,
  output logic warm_rst_o
);
  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  twu_pkg::twu_word_t ts_cnt;
  twu_pkg::twu_word_t gp_cnt [2];
  twu_pkg::twu_reload_t gp_rl [2];
  logic [1:0] gp_en;
  logic [1:0] gp_sr;
  twu_pkg::twu_word_t wd_cnt;
  logic [2:0] wd_ctl;
  logic [15:0] wd_key;
  logic [3:0] ev_sts;
  logic warm;
  wire logic [4:0] sts = {warm, ev_sts};

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  wire logic req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // partial writes dropped; full word only
  wire logic wr = req & wb_we_i & (wb_sel_i == 4'hf);
  wire logic wr_ts = wr & hit(wb_adr_i, `TWU_OFS_TS);
  wire logic [1:0] wr_rl = {wr & hit(wb_adr_i, `TWU_OFS_GP1_RL),
                            wr & hit(wb_adr_i, `TWU_OFS_GP0_RL)};
  wire logic unlocked = (wd_key == `TWU_KEY_VALUE);
  wire logic wr_wd = wr & unlocked & hit(wb_adr_i, `TWU_OFS_WD);
  wire logic wr_wctl = wr & unlocked & hit(wb_adr_i, `TWU_OFS_WD_CTL);
  wire logic wr_key = wr & hit(wb_adr_i, `TWU_OFS_WD_KEY);
  wire logic wr_sts = wr & hit(wb_adr_i, `TWU_OFS_STS);
  wire logic [4:0] clr = wr_sts ? wb_dat_i[4:0] : 5'h00;

  // ----------------------------------------
  // counter events
  // ----------------------------------------
  wire logic tick = ce_i;
  wire logic ts_wrap = tick & (ts_cnt == 32'hffffffff) & ~wr_ts;
  wire logic wd_zero = tick & wd_ctl[`TWU_WCTL_CNT_BIT] & (wd_cnt == 32'h00000000) & ~wr_wd;
  wire logic wd_fire = wd_zero & wd_ctl[`TWU_WCTL_RST_BIT];
  logic [1:0] gp_zero;
  twu_pkg::twu_word_t next_gp_cnt [2];

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gen_gp
      wire twu_pkg::twu_word_t rl_word = {gp_rl[g], 2'b00};
      assign gp_zero[g] = tick & gp_en[g] & (gp_cnt[g] == 32'h00000000) & ~wr_rl[g];
      // zero takes one cycle, so period is 4x+1
      assign next_gp_cnt[g] = wr_rl[g] ? {wb_dat_i[31:2], 2'b00} :
                              gp_zero[g] ? rl_word :
                              (tick & gp_en[g]) ? gp_cnt[g] - 32'h00000001 :
                              gp_cnt[g];
      always_ff @(posedge clk_i) begin
        if (rst_i | chip_rst_o) begin
          gp_cnt[g] <= 32'h00000000;
          gp_rl[g] <= 30'h00000000;
          gp_en[g] <= 1'b0;
          gp_sr[g] <= 1'b0;
        end else begin
          gp_cnt[g] <= next_gp_cnt[g];
          if (wr_rl[g]) begin
            gp_rl[g] <= wb_dat_i[31:2];
            gp_sr[g] <= wb_dat_i[`TWU_RL_SR_BIT];
            gp_en[g] <= wb_dat_i[`TWU_RL_EN_BIT];
          end else if (gp_zero[g] & gp_sr[g]) begin
            gp_en[g] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // status, set wins over clear
  // ----------------------------------------
  wire logic [3:0] ev = {wd_zero & wd_ctl[`TWU_WCTL_INT_BIT], gp_zero, ts_wrap};
  wire logic [3:0] next_sts = ev | (ev_sts & ~clr[3:0]);

  always_ff @(posedge clk_i) begin
    if (rst_i | chip_rst_o) begin
      ev_sts <= 4'h0;
    end else begin
      ev_sts <= next_sts;
    end
  end

  // warm flag survives chip reset, cleared only by rst_i, system reset or write one
  always_ff @(posedge clk_i) begin
    if (rst_i | sys_rst_i) begin
      warm <= 1'b0;
    end else if (chip_rst_o) begin
      warm <= 1'b1;
    end else if (clr[`TWU_ST_WARM_BIT]) begin
      warm <= 1'b0;
    end
  end

  // ----------------------------------------
  // time stamp and watchdog
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i | chip_rst_o) begin
      ts_cnt <= 32'h00000000;
      wd_cnt <= `TWU_WD_RST;
      wd_ctl <= 3'h0;
      wd_key <= 16'h0000;
    end else begin
      if (wr_ts) begin
        ts_cnt <= wb_dat_i;
      end else if (tick) begin
        ts_cnt <= ts_cnt + 32'h00000001;
      end
      if (wr_wd) begin
        wd_cnt <= wb_dat_i;
      end else if (tick & wd_ctl[`TWU_WCTL_CNT_BIT]) begin
        wd_cnt <= wd_cnt - 32'h00000001;
      end
      if (wr_wctl) begin
        wd_ctl <= wb_dat_i[2:0];
      end
      if (wr_key) begin
        wd_key <= wb_dat_i[15:0];
      end
    end
  end

  // chip reset pulse, one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chip_rst_o <= 1'b0;
    end else begin
      chip_rst_o <= wd_fire & ~chip_rst_o;
    end
  end

  // ----------------------------------------
  // read mux and outputs
  // ----------------------------------------
  wire twu_pkg::twu_word_t rd_mux =
    hit(wb_adr_i, `TWU_OFS_TS) ? ts_cnt :
    hit(wb_adr_i, `TWU_OFS_GP0) ? gp_cnt[0] :
    hit(wb_adr_i, `TWU_OFS_GP0_RL) ? {gp_rl[0], gp_sr[0], gp_en[0]} :
    hit(wb_adr_i, `TWU_OFS_GP1) ? gp_cnt[1] :
    hit(wb_adr_i, `TWU_OFS_GP1_RL) ? {gp_rl[1], gp_sr[1], gp_en[1]} :
    hit(wb_adr_i, `TWU_OFS_WD) ? wd_cnt :
    hit(wb_adr_i, `TWU_OFS_WD_CTL) ? {29'h00000000, wd_ctl} :
    hit(wb_adr_i, `TWU_OFS_WD_KEY) ? {16'h0000, wd_key} :
    hit(wb_adr_i, `TWU_OFS_STS) ? {27'h0000000, sts} :
    32'h00000000;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= req ? rd_mux : 32'h00000000;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ts_irq_o <= 1'b0;
      gp0_irq_o <= 1'b0;
      gp1_irq_o <= 1'b0;
      wd_irq_o <= 1'b0;
      warm_rst_o <= 1'b0;
    end else begin
      ts_irq_o <= next_sts[`TWU_ST_TS_BIT] & ~chip_rst_o;
      gp0_irq_o <= next_sts[`TWU_ST_GP0_BIT] & ~chip_rst_o;
      gp1_irq_o <= next_sts[`TWU_ST_GP1_BIT] & ~chip_rst_o;
      wd_irq_o <= next_sts[`TWU_ST_WD_BIT] & ~chip_rst_o;
      warm_rst_o <= warm;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_key_locks_wd: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr & hit(wb_adr_i, `TWU_OFS_WD) & ~unlocked & ~ce_i & ~chip_rst_o) |=> $stable(wd_cnt))
    else $error("watchdog written while locked");
  a_wd_holds: assert property (@(posedge clk_i) disable iff (rst_i)
    (~wd_ctl[`TWU_WCTL_CNT_BIT] & ~wr_wd & ~chip_rst_o) |=> $stable(wd_cnt))
    else $error("watchdog moved while disabled");
  a_wd_irq_set: assert property (@(posedge clk_i) disable iff (rst_i)
    (wd_zero & wd_ctl[`TWU_WCTL_INT_BIT] & ~chip_rst_o) |=> sts[`TWU_ST_WD_BIT] & wd_irq_o)
    else $error("watchdog interrupt missing");
  a_warm_set: assert property (@(posedge clk_i) disable iff (rst_i | sys_rst_i)
    chip_rst_o |=> warm ##1 warm_rst_o)
    else $error("warm flag not set");
  a_ts_counts: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i & ~wr_ts & ~chip_rst_o) |=> ts_cnt == $past(ts_cnt) + 32'h00000001)
    else $error("time stamp not counting");
  a_rl_load: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_rl[0] & ~chip_rst_o) |=> gp_cnt[0] == {$past(wb_dat_i[31:2]), 2'b00})
    else $error("reload not loaded");
  a_single_stop: assert property (@(posedge clk_i) disable iff (rst_i)
    (gp_zero[1] & gp_sr[1] & ~chip_rst_o) |=> ~gp_en[1] & gp1_irq_o)
    else $error("single run did not stop");
  a_periodic_go: assert property (@(posedge clk_i) disable iff (rst_i)
    (gp_zero[0] & ~gp_sr[0] & ~chip_rst_o) |=> gp_en[0] & gp0_irq_o
      & gp_cnt[0] == {gp_rl[0], 2'b00})
    else $error("periodic did not reload");
  a_rsvd_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    (req & hit(wb_adr_i, `TWU_OFS_WD_CTL)) |=> wb_dat_o[31:3] == 29'h00000000)
    else $error("reserved bits nonzero");
endmodule : twu_timer_unit
`default_nettype wire

// >>> verif/tb_twu_timer_unit.sv
`include "twu_defs.svh"
`default_nettype none
module tb_twu_timer_unit;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b0;
  logic sys_rst_i = 1'b0;
  logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, q, rv;
  logic ts_irq_o, gp0_irq_o, gp1_irq_o, wd_irq_o, chip_rst_o, warm_rst_o;
  int n_mismatch = 0;
  int checks_done = 0;
  int cyc_cnt = 0;
  int t1, t2;
  wire [5:0] irqs = {warm_rst_o, chip_rst_o, wd_irq_o, gp1_irq_o, gp0_irq_o, ts_irq_o};
  always #50 clk_i = ~clk_i;
  twu_timer_unit twu_timer_unit_inst (.clk_i, .rst_i, .ce_i, .sys_rst_i, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .ts_irq_o, .gp0_irq_o, .gp1_irq_o, .wd_irq_o, .chip_rst_o, .warm_rst_o);
  twu_sw_model sw (.clk_i, .ack_i(wb_ack_o), .rdat_i(wb_dat_o), .cyc_o(wb_cyc_i),
    .stb_o(wb_stb_i), .we_o(wb_we_i), .adr_o(wb_adr_i), .sel_o(wb_sel_i), .wdat_o(wb_dat_i));
  // ------------------------------
  // checking helpers
  // ------------------------------
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : close_out
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string nm);
    sw.xfer(1'b0, a, 32'h0, q);
    chk(nm, e, q);
  endtask : rd_chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    sw.xfer(1'b1, a, d, q);
  endtask : wr
  task automatic wait_lvl(input int k, input logic v);
    for (int i = 0; i < 300 && irqs[k] !== v; i++) @(posedge clk_i);
    chk("event line", {31'h0, v}, {31'h0, irqs[k]});
  endtask : wait_lvl
  always @(posedge clk_i) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 20000) begin
      n_mismatch++;
      close_out();
    end
  end
  // ------------------------------
  // main sequence
  // ------------------------------
  initial begin
    void'($urandom(42));
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk(`TWU_OFS_WD, `TWU_WD_RST, "wd count");
    rd_chk(`TWU_OFS_WD_CTL, 32'h0, "wd ctl");
    rd_chk(`TWU_OFS_GP0_RL, 32'h0, "gp0 reload");
    rd_chk(8'h24, 32'h0, "unmapped");
    wr(`TWU_OFS_WD, 32'h5);
    rd_chk(`TWU_OFS_WD, `TWU_WD_RST, "locked wd");
    wr(`TWU_OFS_WD_KEY, 32'hffff482e);
    rd_chk(`TWU_OFS_WD_KEY, 32'h482e, "key");
    sw.sel_v = 4'h3;
    wr(`TWU_OFS_WD_KEY, 32'h00000000);
    sw.sel_v = 4'hf;
    rd_chk(`TWU_OFS_WD_KEY, 32'h482e, "key partial");
    wr(`TWU_OFS_WD_CTL, 32'hffffffff);
    rd_chk(`TWU_OFS_WD_CTL, 32'h7, "wd ctl bits");
    sw.wd_set(`TWU_OFS_WD_CTL, 32'h6);
    sw.wd_set(`TWU_OFS_WD, 32'h5);
    rd_chk(`TWU_OFS_WD, 32'h5, "wd loaded");
    ce_i <= 1'b1;
    wait_lvl(3, 1'b1);
    wr(`TWU_OFS_STS, 32'h8);
    wait_lvl(3, 1'b0);
    sw.wd_set(`TWU_OFS_WD_CTL, 32'h0);
    rv = $urandom;
    ce_i <= 1'b0;
    wr(`TWU_OFS_GP0_RL, {rv[31:2], 2'b00});
    rd_chk(`TWU_OFS_GP0, {rv[31:2], 2'b00}, "gp0 load");
    wr(`TWU_OFS_GP0_RL, 32'h0d);
    ce_i <= 1'b1;
    wait_lvl(1, 1'b1);
    t1 = cyc_cnt;
    wr(`TWU_OFS_STS, 32'h2);
    wait_lvl(1, 1'b0);
    wait_lvl(1, 1'b1);
    t2 = cyc_cnt;
    chk("gp0 period", 32'(4 * 3 + 1), 32'(t2 - t1));
    wr(`TWU_OFS_GP0_RL, 32'h0c);
    rd_chk(`TWU_OFS_GP0, 32'h0c, "gp0 stopped");
    wr(`TWU_OFS_STS, 32'h2);
    wr(`TWU_OFS_GP1_RL, 32'h0b);
    wait_lvl(2, 1'b1);
    rd_chk(`TWU_OFS_GP1_RL, 32'h0a, "gp1 single");
    rd_chk(`TWU_OFS_GP1, 32'h08, "gp1 halted");
    wr(`TWU_OFS_STS, 32'h4);
    wait_lvl(2, 1'b0);
    wr(`TWU_OFS_GP1_RL, 32'h0b);
    wait_lvl(2, 1'b1);
    wr(`TWU_OFS_STS, 32'h4);
    wr(`TWU_OFS_TS, 32'hfffffff0);
    wait_lvl(0, 1'b1);
    sw.xfer(1'b0, `TWU_OFS_TS, 32'h0, rv);
    chk("ts wrapped", 32'h0, rv & 32'hffffff00);
    wr(`TWU_OFS_STS, 32'h1);
    wait_lvl(0, 1'b0);
    sw.wd_set(`TWU_OFS_WD, 32'h3);
    sw.wd_set(`TWU_OFS_WD_CTL, 32'h5);
    wait_lvl(4, 1'b1);
    wait_lvl(5, 1'b1);
    rd_chk(`TWU_OFS_WD_CTL, 32'h0, "ctl after reset");
    rd_chk(`TWU_OFS_STS, 32'h10, "warm flag");
    sys_rst_i <= 1'b1;
    @(posedge clk_i);
    sys_rst_i <= 1'b0;
    wait_lvl(5, 1'b0);
    sw.wd_set(`TWU_OFS_WD, 32'h3);
    sw.wd_set(`TWU_OFS_WD_CTL, 32'h5);
    wait_lvl(5, 1'b1);
    wr(`TWU_OFS_STS, 32'h10);
    wait_lvl(5, 1'b0);
    close_out();
  end
endmodule : tb_twu_timer_unit
`default_nettype wire

// >>> verif/twu_sw_model.sv
`include "twu_defs.svh"
`default_nettype none
module twu_sw_model (
  input wire logic clk_i,
  input wire logic ack_i,
  input wire logic [31:0] rdat_i,
  output logic cyc_o,
  output logic stb_o,
  output logic we_o,
  output logic [7:0] adr_o,
  output logic [3:0] sel_o,
  output logic [31:0] wdat_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] sel_v = 4'hf;
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o = 1'b0;
    adr_o = 8'h00;
    sel_o = 4'h0;
    wdat_o = 32'h5a5a5a5a;
  end
  // ------------------------------
  // bus access
  // ------------------------------
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= w;
    adr_o <= a;
    sel_o <= sel_v;
    wdat_o <= d;
    do @(posedge clk_i); while (ack_i !== 1'b1);
    q = rdat_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    wdat_o <= ~d;
  endtask : xfer
  task automatic wd_set(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, `TWU_OFS_WD_KEY, {16'h0000, `TWU_KEY_VALUE}, q);
    xfer(1'b1, a, d, q);
    xfer(1'b1, `TWU_OFS_WD_KEY, 32'h00000000, q);
  endtask : wd_set
endmodule : twu_sw_model
`default_nettype wire
